/* inc/slqc_pkg.sv */
// Constants for the serial link quick configuration block
// Operation
// - The first L of the four lanes form one link
// - Lanes, converters, octets from quick code
// - Lane rate is M*N'*10/8*fout/L
// - Bit 4 selects low line rate
// - 16-bit one converter code table
// - 16-bit two/four converter code table
// - 8-bit one converter code table
// - 8-bit two converter code table
`default_nettype none
package slqc_pkg;
    localparam logic [11:0] LINE_RATE_CONTROL_OFS = 12'h56e;
    localparam logic [11:0] LINK_QUICK_SETUP_OFS  = 12'h570;
    localparam logic [11:0] LINK_CONTROL_OFS      = 12'h571;
    localparam logic [11:0] LINK_STATUS_OFS       = 12'h574;
    localparam logic [11:0] LINK_RATE_OFS         = 12'h575;
    localparam int          LOW_RATE_BIT          = 4;
    localparam int          RATE_FIELD_LSB        = 3;
    localparam int          POWER_DOWN_BIT        = 0;
    localparam int          WIDE_SAMPLE_BIT       = 1;
    localparam logic [7:0]  LINE_RATE_RESET       = 8'h00;
    localparam logic [7:0]  QUICK_SETUP_RESET     = 8'h88;
    localparam logic [7:0]  LINK_CONTROL_RESET    = 8'h03;
    localparam int          DECODE_LATENCY        = 1;
    localparam logic [7:0]  LANE_WEIGHT_FULL      = 8'd10;
    localparam logic [7:0]  LANE_WEIGHT_DIV       = 8'd8;
    localparam int          NUM_LANES             = 4;
endpackage
`default_nettype wire

/* logic/slqc_decode.sv */
// Quick configuration code decoder
`default_nettype none
module slqc_decode
    import slqc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] code,
    input  wire logic       wideSample,
    output logic      [2:0] lanes_q,
    output logic      [2:0] convs_q,
    output logic      [3:0] octets_q,
    output logic      [3:0] samples_q,
    output logic            hiDens_q,
    output logic            valid_q
);
    logic [15:0] entry;
    // Entry is {valid, hd, L, M, F, S}; L, M, F and S hold plain counts
    always_comb begin
        entry = 16'h0000;
        if (wideSample) begin
            case (code)
                8'h01:   entry = {1'b1, 1'b0, 3'd1, 3'd1, 4'd2, 4'd1};
                8'h40:   entry = {1'b1, 1'b1, 3'd2, 3'd1, 4'd1, 4'd1};
                8'h41:   entry = {1'b1, 1'b0, 3'd2, 3'd1, 4'd2, 4'd2};
                8'h80:   entry = {1'b1, 1'b1, 3'd4, 3'd1, 4'd1, 4'd2};
                8'h81:   entry = {1'b1, 1'b0, 3'd4, 3'd1, 4'd2, 4'd4};
                8'h0a:   entry = {1'b1, 1'b0, 3'd1, 3'd2, 4'd4, 4'd1};
                8'h49:   entry = {1'b1, 1'b0, 3'd2, 3'd2, 4'd2, 4'd1};
                8'h88:   entry = {1'b1, 1'b1, 3'd4, 3'd2, 4'd1, 4'd1};
                8'h89:   entry = {1'b1, 1'b0, 3'd4, 3'd2, 4'd2, 4'd2};
                8'h13:   entry = {1'b1, 1'b0, 3'd1, 3'd4, 4'd8, 4'd1};
                8'h52:   entry = {1'b1, 1'b0, 3'd2, 3'd4, 4'd4, 4'd1};
                8'h91:   entry = {1'b1, 1'b0, 3'd4, 3'd4, 4'd2, 4'd1};
                default: entry = 16'h0000;
            endcase
        end else begin
            case (code)
                8'h00:   entry = {1'b1, 1'b0, 3'd1, 3'd1, 4'd1, 4'd1};
                8'h01:   entry = {1'b1, 1'b0, 3'd1, 3'd1, 4'd2, 4'd2};
                8'h40:   entry = {1'b1, 1'b0, 3'd2, 3'd1, 4'd1, 4'd2};
                8'h41:   entry = {1'b1, 1'b0, 3'd2, 3'd1, 4'd2, 4'd4};
                8'h42:   entry = {1'b1, 1'b0, 3'd2, 3'd1, 4'd4, 4'd8};
                8'h80:   entry = {1'b1, 1'b0, 3'd4, 3'd1, 4'd1, 4'd4};
                8'h81:   entry = {1'b1, 1'b0, 3'd4, 3'd1, 4'd2, 4'd8};
                8'h09:   entry = {1'b1, 1'b0, 3'd1, 3'd2, 4'd2, 4'd1};
                8'h48:   entry = {1'b1, 1'b0, 3'd2, 3'd2, 4'd1, 4'd1};
                8'h49:   entry = {1'b1, 1'b0, 3'd2, 3'd2, 4'd2, 4'd2};
                8'h88:   entry = {1'b1, 1'b0, 3'd4, 3'd2, 4'd1, 4'd2};
                8'h89:   entry = {1'b1, 1'b0, 3'd4, 3'd2, 4'd2, 4'd4};
                8'h8a:   entry = {1'b1, 1'b0, 3'd4, 3'd2, 4'd4, 4'd8};
                default: entry = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lanes_q   <= 3'd0;
            convs_q   <= 3'd0;
            octets_q  <= 4'd0;
            samples_q <= 4'd0;
            hiDens_q  <= 1'b0;
            valid_q   <= 1'b0;
        end else begin
            valid_q   <= entry[15];
            hiDens_q  <= entry[14];
            lanes_q   <= entry[13:11];
            convs_q   <= entry[10:8];
            octets_q  <= entry[7:4];
            samples_q <= entry[3:0];
        end
    end
endmodule
`default_nettype wire

/* logic/slqc_top.sv */
// Quick configuration register block for the four-lane serial link
//
// The strobed register port was left to the implementer.
`default_nettype none
module slqc_top
    import slqc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [7:0]  regRdData_q,
    output logic      [2:0]  linkLanes_q,
    output logic      [2:0]  linkConvs_q,
    output logic      [3:0]  linkOctets_q,
    output logic      [3:0]  linkSamples_q,
    output logic             linkHiDens_q,
    output logic      [4:0]  linkResMin_q,
    output logic      [4:0]  linkResMax_q,
    output logic      [1:0]  linkCtrlBitsMax_q,
    output logic             lowLineRate_q,
    output logic      [1:0]  rateField_q,
    output logic             linkPowerDown_q,
    output logic      [NUM_LANES-1:0] laneEnable_q
);
    // ********************************
    // Registers
    // ********************************
    logic [7:0] lineRate_q;
    logic [7:0] quickSetup_q;
    logic [7:0] linkCtrl_q;

    wire selRate  = regAddr == LINE_RATE_CONTROL_OFS;
    wire selQuick = regAddr == LINK_QUICK_SETUP_OFS;
    wire selCtrl  = regAddr == LINK_CONTROL_OFS;
    wire selStat  = regAddr == LINK_STATUS_OFS;
    wire selLrate = regAddr == LINK_RATE_OFS;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lineRate_q   <= LINE_RATE_RESET;
            quickSetup_q <= QUICK_SETUP_RESET;
            linkCtrl_q   <= LINK_CONTROL_RESET;
        end else if (regWrStb) begin
            if (selRate)  lineRate_q   <= regWrData;
            if (selQuick) quickSetup_q <= regWrData;
            if (selCtrl)  linkCtrl_q   <= regWrData;
        end
    end

    // ********************************
    // Decode
    // ********************************
    logic [2:0] decLanes;
    logic [2:0] decConvs;
    logic [3:0] decOctets;
    logic [3:0] decSamples;
    logic       decHiDens;
    logic       decValid;
    wire        wideSample = linkCtrl_q[WIDE_SAMPLE_BIT];
    wire        powerDown  = linkCtrl_q[POWER_DOWN_BIT];

    slqc_decode u_decode (
        .clk       (clk),
        .rst_b     (rst_b),
        .code      (quickSetup_q),
        .wideSample(wideSample),
        .lanes_q   (decLanes),
        .convs_q   (decConvs),
        .octets_q  (decOctets),
        .samples_q (decSamples),
        .hiDens_q  (decHiDens),
        .valid_q   (decValid)
    );

    // Lane rate per f_out, truncated to a whole multiple: M*N'*10/8/L
    wire [7:0] nPrime   = wideSample ? 8'd16 : 8'd8;
    // Wide product first: M*N'*10 reaches 640 before the divide by 8
    wire [15:0] mulWide = (16'(linkConvs_q) * 16'(nPrime) * 16'(LANE_WEIGHT_FULL))
                          / 16'(LANE_WEIGHT_DIV);
    wire [7:0] mulRate  = mulWide[7:0];
    wire [7:0] rateMult = (linkLanes_q == 3'd0) ? 8'h00 : 8'(mulRate / 8'(linkLanes_q));

    // ********************************
    // Applied settings
    // ********************************
    // Only a powered-down link takes new settings, so a live link never glitches
    wire applyNow = powerDown && decValid;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkLanes_q       <= 3'd0;
            linkConvs_q       <= 3'd0;
            linkOctets_q      <= 4'd0;
            linkSamples_q     <= 4'd0;
            linkHiDens_q      <= 1'b0;
            linkResMin_q      <= 5'd0;
            linkResMax_q      <= 5'd0;
            linkCtrlBitsMax_q <= 2'd0;
            lowLineRate_q     <= 1'b0;
            rateField_q       <= 2'd0;
        end else if (applyNow) begin
            linkLanes_q       <= decLanes;
            linkConvs_q       <= decConvs;
            linkOctets_q      <= decOctets;
            linkSamples_q     <= decSamples;
            linkHiDens_q      <= decHiDens;
            linkResMin_q      <= wideSample ? 5'd8 : 5'd7;
            linkResMax_q      <= wideSample ? 5'd16 : 5'd8;
            linkCtrlBitsMax_q <= wideSample ? 2'd3 : 2'd1;
            lowLineRate_q     <= lineRate_q[LOW_RATE_BIT];
            rateField_q       <= lineRate_q[RATE_FIELD_LSB +: 2];
        end
    end

    // Lanes run as one link: lanes below linkLanes_q power up together, the rest stay off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            linkPowerDown_q <= 1'b1;
            laneEnable_q    <= '0;
        end else begin
            linkPowerDown_q <= powerDown;
            for (int i = 0; i < NUM_LANES; i++) begin
                laneEnable_q[i] <= !powerDown && (i < int'(linkLanes_q));
            end
        end
    end

    // ********************************
    // Read back
    // ********************************
    wire [7:0] statusWord = {3'b000, decValid, decHiDens, linkLanes_q};
    wire [7:0] rdMux = selRate  ? lineRate_q   :
                       selQuick ? quickSetup_q :
                       selCtrl  ? linkCtrl_q   :
                       selStat  ? statusWord   :
                       selLrate ? rateMult     : 8'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_q <= 8'h00;
        end else begin
            regRdData_q <= regRdStb ? rdMux : 8'h00;
        end
    end

    // ********************************
    // Checks
    // ********************************
    sequence s_apply;
        powerDown && decValid;
    endsequence

    a_hold_while_up: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(powerDown) |-> $stable(linkLanes_q))
        else $error("Link parameters changed while powered up");
    a_low_rate_copy: assert property (@(posedge clk) disable iff (!rst_b)
        s_apply |=> lowLineRate_q == $past(lineRate_q[LOW_RATE_BIT]))
        else $error("Low line rate select not applied");
    a_lanes_apply: assert property (@(posedge clk) disable iff (!rst_b)
        s_apply |=> linkLanes_q == $past(decLanes))
        else $error("Lane count not applied");
    a_lanes_single: assert property (@(posedge clk) disable iff (!rst_b)
        linkPowerDown_q |-> laneEnable_q == '0)
        else $error("Lane enabled while link down");
    a_code_wide: assert property (@(posedge clk) disable iff (!rst_b)
        wideSample && quickSetup_q == 8'h91 && $stable(quickSetup_q) && $stable(wideSample)
        |=> decLanes == 3'd4 && decConvs == 3'd4 && decOctets == 4'd2)
        else $error("Code 0x91 mis-decoded");
    a_code_one: assert property (@(posedge clk) disable iff (!rst_b)
        wideSample && quickSetup_q == 8'h40 && $stable(quickSetup_q) && $stable(wideSample)
        |=> decHiDens && decLanes == 3'd2)
        else $error("Code 0x40 mis-decoded");
    a_code_narrow: assert property (@(posedge clk) disable iff (!rst_b)
        !wideSample && quickSetup_q == 8'h42 && $stable(quickSetup_q) && $stable(wideSample)
        |=> decSamples == 4'd8 && decOctets == 4'd4)
        else $error("Code 0x42 mis-decoded");
    a_code_two: assert property (@(posedge clk) disable iff (!rst_b)
        !wideSample && $past(!wideSample) |-> !decHiDens)
        else $error("High density set for narrow samples");
    a_read_data: assert property (@(posedge clk) disable iff (!rst_b)
        regRdStb && selQuick |=> regRdData_q == $past(quickSetup_q))
        else $error("Read data wrong");
endmodule
`default_nettype wire

/* testbench/slqc_rx_model.sv */
// Link receiver model watching the lane enables of the transmit link
`default_nettype none
module slqc_rx_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] laneEnable,
    output logic      [2:0] rxLanes_q,
    output logic            rxSplit_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Lane grouping
    // ****************************************
    // One link only, so live lanes must run upward from lane 0
    wire logic split = !(laneEnable inside {4'h0, 4'h1, 4'h3, 4'hf});
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxLanes_q <= 3'h0;
            rxSplit_q <= 1'b0;
        end else begin
            rxLanes_q <= 3'($countones(laneEnable));
            rxSplit_q <= rxSplit_q | split;
        end
    end
endmodule
`default_nettype wire

/* testbench/test_serial_link_quick_config.sv */
// Self-checking testbench for the quick configuration register block
`default_nettype none
module test_serial_link_quick_config;
    timeunit 1ns;
    timeprecision 1ps;
    import slqc_pkg::*;
    logic                 clk = 1'b0;
    logic                 rst_b, regWrStb, regRdStb, linkHiDens_q, lowLineRate_q;
    logic                 linkPowerDown_q, rxSplit_q;
    logic [11:0]          regAddr;
    logic [7:0]           regWrData, regRdData_q;
    logic [2:0]           linkLanes_q, linkConvs_q, rxLanes_q;
    logic [3:0]           linkOctets_q, linkSamples_q;
    logic [4:0]           linkResMin_q, linkResMax_q;
    logic [1:0]           linkCtrlBitsMax_q, rateField_q;
    logic [NUM_LANES-1:0] laneEnable_q;
    int                   nFail = 0, nTests = 0, cycles = 0;
    // Frames per multiframe kept at 32, legal for every F
    localparam int        K_FRAMES = 32;
    // Wide flag, code, L, M, F, S, HD; every entry usable in the legal rate span
    localparam logic [31:0] CFG [25] = '{
        32'h10111210, 32'h14021111, 32'h14121220, 32'h18041121, 32'h18141240,
        32'h10a12410, 32'h14922210, 32'h18842111, 32'h18942220, 32'h11314810,
        32'h15224410, 32'h19144210, 32'h00011110, 32'h00111220, 32'h04021120,
        32'h04121240, 32'h04221480, 32'h08041140, 32'h08141280, 32'h00912210,
        32'h04822110, 32'h04922220, 32'h08842120, 32'h08942240, 32'h08a42480};

    slqc_top i_slqc_top (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData_q(regRdData_q), .linkLanes_q(linkLanes_q), .linkConvs_q(linkConvs_q),
        .linkOctets_q(linkOctets_q), .linkSamples_q(linkSamples_q),
        .linkHiDens_q(linkHiDens_q), .linkResMin_q(linkResMin_q),
        .linkResMax_q(linkResMax_q), .linkCtrlBitsMax_q(linkCtrlBitsMax_q),
        .lowLineRate_q(lowLineRate_q), .rateField_q(rateField_q),
        .linkPowerDown_q(linkPowerDown_q), .laneEnable_q(laneEnable_q));
    slqc_rx_model i_slqc_rx_model (.clk(clk), .rst_b(rst_b), .laneEnable(laneEnable_q),
        .rxLanes_q(rxLanes_q), .rxSplit_q(rxSplit_q));

    always #12.5 clk = ~clk;
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            nFail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        d = regRdData_q;
    endtask
    // Apply takes two edges, lane enables and the receiver one more each
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        if (nFail == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        logic [7:0] d;
        check(linkPowerDown_q, 8'h01);
        rd(LINE_RATE_CONTROL_OFS, d);
        check(d, LINE_RATE_RESET);
        rd(LINK_QUICK_SETUP_OFS, d);
        check(d, QUICK_SETUP_RESET);
        wr(12'h100, 8'h5a);
        rd(12'h100, d);
        check(d, 8'h00);
    endtask
    task automatic test_tables();
        logic [31:0] e;
        logic [7:0]  d;
        int          r;
        for (int i = 0; i < 25; i++) begin
            e = CFG[i];
            r = (int'(e[15:12]) * (e[28] ? 16 : 8) * 10 / 8) / int'(e[19:16]);
            wr(LINK_CONTROL_OFS, {6'h00, e[28], 1'b1});
            wr(LINK_QUICK_SETUP_OFS, e[27:20]);
            settle();
            check(linkLanes_q, e[19:16]);
            check(linkConvs_q, e[15:12]);
            check(linkOctets_q, e[11:8]);
            check(linkSamples_q, e[7:4]);
            check(linkHiDens_q, e[3:0]);
            check(linkResMin_q, e[28] ? 8'h08 : 8'h07);
            check(linkResMax_q, e[28] ? 8'h10 : 8'h08);
            check(linkCtrlBitsMax_q, e[28] ? 8'h03 : 8'h01);
            rd(LINK_QUICK_SETUP_OFS, d);
            check(d, e[27:20]);
            rd(LINK_RATE_OFS, d);
            check(d, 8'(r));
            rd(LINK_STATUS_OFS, d);
            check(d, {3'b000, 1'b1, e[0], e[18:16]});
            check(8'(K_FRAMES >= (e[11:8] == 4'd1 ? 20 : e[11:8] == 4'd2 ? 12 : 8)), 8'h01);
        end
    endtask
    task automatic test_power();
        logic [7:0] d;
        wr(LINK_CONTROL_OFS, 8'h03);
        wr(LINK_QUICK_SETUP_OFS, 8'h91);
        wr(LINE_RATE_CONTROL_OFS, 8'h00);
        // Undefined code must leave the last good set in place
        wr(LINK_QUICK_SETUP_OFS, 8'h02);
        settle();
        check(linkLanes_q, 8'h04);
        check(linkOctets_q, 8'h02);
        wr(LINK_CONTROL_OFS, 8'h02);
        settle();
        check(linkPowerDown_q, 8'h00);
        check(laneEnable_q, 8'h0f);
        check(rxLanes_q, 8'h04);
        wr(LINK_QUICK_SETUP_OFS, 8'h01);
        wr(LINE_RATE_CONTROL_OFS, 8'h10);
        settle();
        check(linkLanes_q, 8'h04);
        check(lowLineRate_q, 8'h00);
        rd(LINE_RATE_CONTROL_OFS, d);
        check(d, 8'h10);
        wr(LINK_CONTROL_OFS, 8'h03);
        settle();
        check(lowLineRate_q, 8'h01);
        check(rateField_q, 8'h02);
        check(linkLanes_q, 8'h01);
        wr(LINK_CONTROL_OFS, 8'h02);
        settle();
        check(laneEnable_q, 8'h01);
        check(rxLanes_q, 8'h01);
        check(rxSplit_q, 8'h00);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nFail++;
            tally_and_finish();
        end
    end
    initial begin
        rst_b = 1'b0;
        regAddr = 12'h000;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        test_reset();
        test_tables();
        test_power();
        tally_and_finish();
    end
endmodule
`default_nettype wire
